/* File: design/adc_ctrl_pkg.sv */
package adc_ctrl_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_SCTL = 8'h04;
   localparam logic [7:0] OFS_NCTL = 8'h08;
   localparam logic [7:0] OFS_MASK = 8'h0c;
   localparam logic [7:0] OFS_THR = 8'h10;
   localparam logic [7:0] OFS_CMD = 8'h14;
   localparam logic [7:0] OFS_STAT = 8'h18;
   localparam logic [7:0] OFS_SDATA = 8'h1c;
   localparam logic [7:0] OFS_SPEEK = 8'h20;
   localparam logic [7:0] OFS_NDATA = 8'h24;
   localparam logic [7:0] OFS_NDATX = 8'h28;
   localparam logic [7:0] OFS_NPEEK = 8'h2c;
   // control fields
   localparam int CTRL_EN = 0;
   localparam int CTRL_ASYNC = 1;
   localparam int CTRL_ONDEM = 2;
   localparam int CTRL_WARM = 3;
   localparam int CTRL_ENGINE_PRESCALE = 8;
   localparam int CTRL_TICK = 16;
   // mode control fields, same layout for single and scan
   localparam int MC_REP = 0;
   localparam int MC_DIFFERENTIAL_SELECT = 1;
   localparam int MC_CMP = 2;
   localparam int MC_ACQ = 4;
   localparam int MC_POS = 8;
   localparam int MC_NEG = 16;
   localparam int MC_RES = 22;
   localparam int MC_OVW = 24;
   localparam int MC_WM = 26;
   localparam int MC_GAP = 28;
   localparam int THR_GT = 0;
   localparam int THR_LT = 16;
   // command and status bits
   localparam int CMD_SSTART = 0;
   localparam int CMD_NSTART = 1;
   localparam int CMD_SSTOP = 2;
   localparam int CMD_NSTOP = 3;
   localparam int SB_SDV = 0;
   localparam int SB_NDV = 1;
   localparam int SB_BUSY = 2;
   localparam int SB_WARM = 3;
   localparam int SB_REQ = 4;
   localparam int SB_EV = 8;
   // sticky event indices
   localparam int EV_SOVF = 0;
   localparam int EV_SUNF = 1;
   localparam int EV_NOVF = 2;
   localparam int EV_NUNF = 3;
   localparam int EV_SCMP = 4;
   localparam int EV_NCMP = 5;
   localparam int EV_PAIR = 6;
   // reset values
   localparam logic [31:0] CTRL_RST = 32'h0000_0004;
   localparam logic [31:0] MODE_RST = 32'h0000_0000;
   localparam logic [31:0] MASK_RST = 32'h0000_0000;
   localparam logic [31:0] THR_RST = 32'h0000_0000;
   // timing
   localparam logic [2:0] WARM_TICKS = 3'd5;
   localparam int FIFO_DEPTH = 4;
   typedef enum logic [2:0] {S_IDLE, S_WARM, S_ACQ, S_APPROX, S_GAP} state_t;
endpackage : adc_ctrl_pkg

/* File: design/sar_adc_ctrl.sv */
`timescale 1ns/1ps
// Summary of operation
// - bus-side registers apart from engine logic
// - engine runs on bus clock or async clock
// - prescaler divides engine clock 1 to 128
// - warm-up counted in engine clock cycles
// - on-demand normal: request only while converting
// - other policies keep async request asserted
// - conversion is acquisition then approximation
// - per-mode acquisition 1,2,3 or 4..256 cycles
// - approximation takes resolution bits plus one
// - each mode own config, fifo, repeat
// - scan priority, single interleaved between samples
// - data valid at watermark, clears below it
// - full fifo discards or overwrites per setting
// - peek returns newest entry of its mode, no pop
// - differential bit and input selects drive core
// - compare new results, raise compare event
// - inside window if above < below, else outside
// - scan mask inputs ascending from lowest
// - scan entries tagged; tagged, untagged, peek reads
// - repeat with no gap tags last input zero
// - warm-up five ticks on the first trigger after enable, and again after each idle with warm mode 0
// - same-bus differential pair raises program error
module sar_adc_ctrl #(
   parameter int NCH = 32,
   parameter int DEPTH = adc_ctrl_pkg::FIFO_DEPTH
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic async_source_clock,
   input wire logic [11:0] ana_result,
   output logic async_clk_req,
   output logic ana_power,
   output logic ana_acquire,
   output logic ana_approx,
   output logic ana_differential_select,
   output logic [4:0] ana_pos_sel,
   output logic [4:0] ana_neg_sel,
   output logic [1:0] ana_res_sel
);
   import adc_ctrl_pkg::*;

   function automatic logic [8:0] acq_len(input logic [3:0] c);
      if (c < 4'd3)
         acq_len = 9'(c) + 9'd1;
      else if (c > 4'd9)
         acq_len = 9'd256;
      else
         acq_len = 9'd4 << (c - 4'd3);
   endfunction : acq_len

   function automatic logic [3:0] res_bits(input logic [1:0] r);
      res_bits = (r == 2'd0) ? 4'd12 : (r == 2'd1) ? 4'd8 : 4'd6;
   endfunction : res_bits

   function automatic logic [4:0] lowest(input logic [NCH-1:0] m);
      lowest = 5'd0;
      for (int i = NCH - 1; i >= 0; i--) begin
         if (m[i])
            lowest = 5'(i);
      end
   endfunction : lowest

   logic rst_s1, rst_n;
   logic [31:0] ctrl_r, sctl_r, nctl_r, mask_r, thr_r;
   logic [6:0] ev_r;
   logic as1_r, as2_r, as3_r, eng_en, conv_tick;
   logic [6:0] pcnt_r;
   logic [7:0] wtick_r;
   logic [2:0] wcnt_r;
   logic warm_r, warm_done;
   state_t state_r;
   logic [8:0] cyc_r;
   logic spend_r, npend_r, last_scan_r, job_single_r;
   logic [NCH-1:0] nleft_r, nleft_nxt;
   logic [4:0] job_ch_r;
   logic work, pick_single, acq_end, apx_end;
   logic [31:0] jctl;
   logic [16:0] mem_r [2][DEPTH];
   logic [1:0] wp_r [2];
   logic [1:0] rp_r [2];
   logic [2:0] cnt_r [2];
   logic [1:0] push, pop, dv;
   logic [16:0] push_d;
   logic cmp_hit, wr_do, rd_do, hit;
   logic [31:0] rd_val;
   logic [11:0] gt, lt;

   // reset release through two flops
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rst_s1 <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_s1 <= 1'b1;
         rst_n <= rst_s1;
      end
   end

   // bus side: apb slave, one wait cycle per access
   assign hit = (paddr[1:0] == 2'b00) && (paddr <= OFS_NPEEK);
   assign wr_do = psel && penable && pready && pwrite && hit;
   assign rd_do = psel && penable && pready && !pwrite && hit;
   assign gt = thr_r[THR_GT +: 12];
   assign lt = thr_r[THR_LT +: 12];

   always_comb begin
      rd_val = 32'h0000_0000;
      case (paddr)
         OFS_CTRL: rd_val = ctrl_r;
         OFS_SCTL: rd_val = sctl_r;
         OFS_NCTL: rd_val = nctl_r;
         OFS_MASK: rd_val = mask_r;
         OFS_THR: rd_val = thr_r;
         OFS_STAT: begin
            rd_val[SB_SDV] = dv[0];
            rd_val[SB_NDV] = dv[1];
            rd_val[SB_BUSY] = (state_r != S_IDLE);
            rd_val[SB_WARM] = warm_r;
            rd_val[SB_REQ] = async_clk_req;
            rd_val[SB_EV +: 7] = ev_r;
         end
         OFS_SDATA, OFS_NDATA: rd_val[11:0] =
            mem_r[paddr == OFS_NDATA][rp_r[paddr == OFS_NDATA]][11:0];
         OFS_NDATX: rd_val = {11'h000, mem_r[1][rp_r[1]][16:12],
            4'h0, mem_r[1][rp_r[1]][11:0]};
         OFS_SPEEK: rd_val[11:0] = mem_r[0][wp_r[0] - 2'd1][11:0];
         OFS_NPEEK: rd_val = {11'h000, mem_r[1][wp_r[1] - 2'd1][16:12],
            4'h0, mem_r[1][wp_r[1] - 2'd1][11:0]};
         default: rd_val = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && penable && !pready;
         if (psel && penable && !pready) begin
            prdata <= hit ? rd_val : 32'h0000_0000;
            pslverr <= !hit;
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_r <= CTRL_RST;
         sctl_r <= MODE_RST;
         nctl_r <= MODE_RST;
         mask_r <= MASK_RST;
         thr_r <= THR_RST;
      end else if (wr_do) begin
         case (paddr)
            OFS_CTRL: ctrl_r <= pwdata;
            OFS_SCTL: sctl_r <= pwdata;
            OFS_NCTL: nctl_r <= pwdata;
            OFS_MASK: mask_r <= pwdata;
            OFS_THR: thr_r <= pwdata;
            default: ;
         endcase
      end
   end

   // engine clock: bus clock, or synchronised async source edges
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         as1_r <= 1'b0;
         as2_r <= 1'b0;
         as3_r <= 1'b0;
      end else begin
         as1_r <= async_source_clock;
         as2_r <= as1_r;
         as3_r <= as2_r;
      end
   end
   assign eng_en = ctrl_r[CTRL_ASYNC] ? (as2_r && !as3_r) : 1'b1;

   // prescaler forms the conversion clock enable
   assign conv_tick = eng_en && (pcnt_r == ctrl_r[CTRL_ENGINE_PRESCALE +: 7]);
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n)
         pcnt_r <= 7'h00;
      else if (conv_tick)
         pcnt_r <= 7'h00;
      else if (eng_en)
         pcnt_r <= pcnt_r + 7'd1;
   end

   // warm-up: five ticks of engine cycles
   assign warm_done = (state_r == S_WARM) && eng_en
      && (wtick_r == ctrl_r[CTRL_TICK +: 8]) && (wcnt_r == WARM_TICKS - 3'd1);
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         wtick_r <= 8'h00;
         wcnt_r <= 3'd0;
      end else if (state_r != S_WARM) begin
         wtick_r <= 8'h00;
         wcnt_r <= 3'd0;
      end else if (eng_en) begin
         if (wtick_r == ctrl_r[CTRL_TICK +: 8]) begin
            wtick_r <= 8'h00;
            wcnt_r <= wcnt_r + 3'd1;
         end else
            wtick_r <= wtick_r + 8'd1;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n)
         warm_r <= 1'b0;
      else if (warm_done)
         warm_r <= 1'b1;
      else if (!ctrl_r[CTRL_EN])
         warm_r <= 1'b0;
      else if (state_r == S_IDLE && !work
            && ctrl_r[CTRL_WARM +: 2] == 2'd0)
         warm_r <= 1'b0;
   end

   // job selection: scan first, single slots between scan samples
   assign work = spend_r || npend_r;
   assign pick_single = spend_r && (!npend_r || last_scan_r);
   assign jctl = job_single_r ? sctl_r : nctl_r;
   assign acq_end = state_r == S_ACQ && conv_tick
      && cyc_r == acq_len(jctl[MC_ACQ +: 4]) - 9'd1;
   assign apx_end = state_r == S_APPROX && conv_tick
      && cyc_r == 9'(res_bits(jctl[MC_RES +: 2]));
   always_comb begin
      nleft_nxt = nleft_r;
      nleft_nxt[job_ch_r] = 1'b0;
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= S_IDLE;
         cyc_r <= 9'h000;
         job_single_r <= 1'b0;
         job_ch_r <= 5'd0;
         last_scan_r <= 1'b0;
      end else begin
         case (state_r)
            S_IDLE: if (ctrl_r[CTRL_EN] && work) begin
               job_single_r <= pick_single;
               job_ch_r <= lowest(nleft_r);
               cyc_r <= 9'h000;
               state_r <= warm_r ? S_ACQ : S_WARM;
            end
            S_WARM: if (warm_done)
               state_r <= S_ACQ;
            S_ACQ: if (acq_end) begin
               cyc_r <= 9'h000;
               state_r <= S_APPROX;
            end else if (conv_tick)
               cyc_r <= cyc_r + 9'd1;
            S_APPROX: if (apx_end) begin
               cyc_r <= 9'h000;
               last_scan_r <= !job_single_r;
               state_r <= (!job_single_r && nleft_nxt == '0
                  && nctl_r[MC_REP] && nctl_r[MC_GAP +: 3] != 3'd0)
                  ? S_GAP : S_IDLE;
            end else if (conv_tick)
               cyc_r <= cyc_r + 9'd1;
            S_GAP: if (conv_tick) begin
               cyc_r <= cyc_r + 9'd1;
               if (cyc_r == 9'(nctl_r[MC_GAP +: 3]) - 9'd1)
                  state_r <= S_IDLE;
            end
            default: state_r <= S_IDLE;
         endcase
         if (!ctrl_r[CTRL_EN])
            state_r <= S_IDLE;
      end
   end

   // pending triggers and the remaining scan inputs
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         spend_r <= 1'b0;
         npend_r <= 1'b0;
         nleft_r <= '0;
      end else begin
         if (apx_end && job_single_r && !sctl_r[MC_REP])
            spend_r <= 1'b0;
         if (apx_end && !job_single_r) begin
            nleft_r <= nleft_nxt;
            if (nleft_nxt == '0 && !nctl_r[MC_REP])
               npend_r <= 1'b0;
            else if (nleft_nxt == '0 && nctl_r[MC_GAP +: 3] == 3'd0)
               nleft_r <= mask_r[NCH-1:0];
         end
         if (state_r == S_GAP && state_r != S_IDLE && nleft_r == '0)
            nleft_r <= mask_r[NCH-1:0];
         if (wr_do && paddr == OFS_CMD) begin
            if (pwdata[CMD_SSTART])
               spend_r <= 1'b1;
            if (pwdata[CMD_NSTART] && mask_r[NCH-1:0] != '0) begin
               npend_r <= 1'b1;
               nleft_r <= mask_r[NCH-1:0];
            end
            if (pwdata[CMD_SSTOP])
               spend_r <= 1'b0;
            if (pwdata[CMD_NSTOP])
               npend_r <= 1'b0;
         end
      end
   end

   // result path: tag, compare and push into the mode fifo
   assign push = {apx_end && !job_single_r, apx_end && job_single_r};
   assign push_d = {(!job_single_r && nctl_r[MC_REP] && nleft_nxt == '0
      && nctl_r[MC_GAP +: 3] == 3'd0) ? 5'd0 : job_ch_r,
      ana_result};
   assign cmp_hit = jctl[MC_CMP] && ((gt < lt)
      ? (ana_result > gt && ana_result < lt)
      : (ana_result > gt || ana_result < lt));
   assign pop = {rd_do && (paddr == OFS_NDATA || paddr == OFS_NDATX),
      rd_do && paddr == OFS_SDATA};

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         for (int m = 0; m < 2; m++) begin
            wp_r[m] <= 2'd0;
            rp_r[m] <= 2'd0;
            cnt_r[m] <= 3'd0;
            for (int i = 0; i < DEPTH; i++)
               mem_r[m][i] <= 17'h00000;
         end
      end else begin
         for (int m = 0; m < 2; m++) begin
            logic dop, full, wr, drop;
            dop = pop[m] && cnt_r[m] != 3'd0;
            full = cnt_r[m] == 3'(DEPTH) && !dop;
            wr = push[m] && (!full || jctl[MC_OVW]);
            drop = push[m] && full && jctl[MC_OVW];
            if (wr) begin
               mem_r[m][wp_r[m]] <= push_d;
               wp_r[m] <= wp_r[m] + 2'd1;
            end
            if (dop || drop)
               rp_r[m] <= rp_r[m] + 2'd1;
            cnt_r[m] <= cnt_r[m] + 3'(wr) - 3'(dop) - 3'(drop);
         end
      end
   end

   // data valid per mode at the watermark
   assign dv[0] = cnt_r[0] >= 3'(sctl_r[MC_WM +: 2]) + 3'd1;
   assign dv[1] = cnt_r[1] >= 3'(nctl_r[MC_WM +: 2]) + 3'd1;

   // sticky events, write one to clear, a new event wins
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n)
         ev_r <= 7'h00;
      else begin
         for (int e = 0; e < 7; e++) begin
            if (wr_do && paddr == OFS_STAT && pwdata[SB_EV + e])
               ev_r[e] <= 1'b0;
         end
         for (int m = 0; m < 2; m++) begin
            if (push[m] && cnt_r[m] == 3'(DEPTH) && !pop[m])
               ev_r[EV_SOVF + 2 * m] <= 1'b1;
            if (pop[m] && cnt_r[m] == 3'd0)
               ev_r[EV_SUNF + 2 * m] <= 1'b1;
            if (push[m] && cmp_hit)
               ev_r[EV_SCMP + m] <= 1'b1;
         end
         if (acq_end && jctl[MC_DIFFERENTIAL_SELECT] && ana_pos_sel[0] == ana_neg_sel[0])
            ev_r[EV_PAIR] <= 1'b1;
      end
   end

   // analog core controls and the async clock request
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         async_clk_req <= 1'b0;
         ana_power <= 1'b0;
         ana_acquire <= 1'b0;
         ana_approx <= 1'b0;
         ana_differential_select <= 1'b0;
         ana_pos_sel <= 5'd0;
         ana_neg_sel <= 5'd0;
         ana_res_sel <= 2'd0;
      end else begin
         if (ctrl_r[CTRL_ONDEM] && ctrl_r[CTRL_WARM +: 2] == 2'd0)
            async_clk_req <= ctrl_r[CTRL_ASYNC] && ctrl_r[CTRL_EN]
               && (work || state_r != S_IDLE);
         else
            async_clk_req <= ctrl_r[CTRL_ASYNC] && ctrl_r[CTRL_EN];
         ana_power <= warm_r || state_r == S_WARM;
         ana_acquire <= state_r == S_ACQ;
         ana_approx <= state_r == S_APPROX;
         ana_differential_select <= jctl[MC_DIFFERENTIAL_SELECT];
         ana_pos_sel <= job_single_r ? sctl_r[MC_POS +: 5] : job_ch_r;
         ana_neg_sel <= jctl[MC_NEG +: 5];
         ana_res_sel <= jctl[MC_RES +: 2];
      end
   end

   // checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   logic [7:0] tgap_r;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n)
         tgap_r <= 8'h00;
      else
         tgap_r <= conv_tick ? 8'h00 : tgap_r + 8'd1;
   end

   sync_engine_a: assert property (!ctrl_r[CTRL_ASYNC] |-> eng_en)
      else $error("sync mode engine enable low");
   // first tick after a control write may come late, so skip it
   logic tick_seen_r;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n)
         tick_seen_r <= 1'b0;
      else if (wr_do && paddr == OFS_CTRL)
         tick_seen_r <= 1'b0;
      else if (conv_tick)
         tick_seen_r <= 1'b1;
   end

   // conversion ticks spent in the approximation phase
   logic [4:0] apx_tk_r;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n)
         apx_tk_r <= 5'd0;
      else if (state_r != S_APPROX)
         apx_tk_r <= 5'd0;
      else if (conv_tick)
         apx_tk_r <= apx_tk_r + 5'd1;
   end

   engine_prescale_gap_a: assert property (conv_tick && tick_seen_r
      && !ctrl_r[CTRL_ASYNC] |-> tgap_r == 8'(ctrl_r[CTRL_ENGINE_PRESCALE +: 7]))
      else $error("prescaler period wrong");
   req_drop_a: assert property (ctrl_r[CTRL_ONDEM]
      && ctrl_r[CTRL_WARM +: 2] == 2'd0 && state_r == S_IDLE && !work
      && $stable(ctrl_r) |=> !async_clk_req)
      else $error("async request not withdrawn");
   req_hold_a: assert property (ctrl_r[CTRL_ASYNC] && ctrl_r[CTRL_EN]
      && !ctrl_r[CTRL_ONDEM] |=> async_clk_req)
      else $error("async request dropped");
   acq_to_apx_a: assert property (acq_end |=> state_r == S_APPROX
      && ana_acquire && cyc_r == 9'h000)
      else $error("acquisition did not hand over");
   apx_len_a: assert property ($fell(state_r == S_APPROX)
      && $past(ctrl_r[CTRL_EN])
      |-> apx_tk_r == 5'(res_bits(ana_res_sel)) + 5'd1)
      else $error("approximation length wrong");
   ovf_keep_a: assert property (push[0] && cnt_r[0] == 3'(DEPTH) && !pop[0]
      && !sctl_r[MC_OVW] |=> cnt_r[0] == 3'(DEPTH) && ev_r[EV_SOVF]
      && $stable(wp_r[0]))
      else $error("discard policy broken");
   dv_level_a: assert property ($rose(dv[0]) && $stable(sctl_r)
      |-> cnt_r[0] == 3'(sctl_r[MC_WM +: 2]) + 3'd1)
      else $error("data valid at wrong level");
   scan_order_a: assert property (push[1] |-> (nleft_r
      & ((NCH'(1) << job_ch_r) - NCH'(1))) == '0)
      else $error("scan input out of order");
   cmp_in_a: assert property (push[0] && sctl_r[MC_CMP] && gt < lt
      && ana_result > gt && ana_result < lt |=> ev_r[EV_SCMP])
      else $error("window match missed");
   single_cv: cover property (push[0] ##[1:300] push[1]);
   overwrite_cv: cover property (push[1] && cnt_r[1] == 3'(DEPTH));
   interleave_cv: cover property (push[1] ##[1:300] push[0]
      ##[1:300] push[1]);
endmodule : sar_adc_ctrl

/* File: verification/sar_core_model.sv */
`timescale 1ns/1ps
module sar_core_model (
   input wire logic mclk,
   input wire logic ana_approx,
   input wire logic [4:0] ana_pos_sel,
   input wire logic [11:0] base,
   output logic [11:0] ana_result
);
   initial ana_result = 12'h5a5;
   // valid only while approximating, else toggles every cycle
   always @(posedge mclk) begin
      if (ana_approx) begin
         ana_result <= base + 12'(ana_pos_sel);
      end else begin
         ana_result <= ~ana_result;
      end
   end
endmodule : sar_core_model

/* File: verification/sar_adc_sequencer_control_tb_top.sv */
`timescale 1ns/1ps
module sar_adc_sequencer_control_tb_top;
   import adc_ctrl_pkg::*;
   logic mclk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, async_source_clock = 1'b0, req_seen = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, r, m;
   logic [11:0] base = 12'h0, ana_result, b;
   logic [4:0] ana_pos_sel, p;
   logic pready, pslverr, err, async_clk_req, ana_acquire, ana_approx;
   int miscompares = 0, cmp_count = 0, ndone = 0, acq_c = 0, apx_c = 0;
   int acq_len = 0, apx_len = 0, k;
   int ch[3];
   logic [11:0] q[5];
   logic [7:0] ofs[5] = '{OFS_CTRL, OFS_SCTL, OFS_NCTL, OFS_MASK, OFS_THR};
   logic [31:0] rv[5] = '{CTRL_RST, MODE_RST, MODE_RST, MASK_RST, THR_RST};
   int codes[4] = '{0, 2, 3, 9};
   logic [11:0] gt[4] = '{12'h100, 12'h100, 12'h200, 12'h200};
   logic [11:0] vl[4] = '{12'h180, 12'h280, 12'h180, 12'h280};
   logic [3:0] hit = 4'b1001;

   sar_adc_ctrl sar_adc_ctrl_i (.mclk, .rst_b, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .async_source_clock,
      .ana_result, .async_clk_req, .ana_power(), .ana_acquire, .ana_approx,
      .ana_differential_select(), .ana_pos_sel, .ana_neg_sel(), .ana_res_sel());
   sar_core_model sar_core_model_i (.mclk, .ana_approx, .ana_pos_sel,
      .base, .ana_result);

   always #12.5 mclk = ~mclk;
   // 20 MHz engine clock keeps the bus clock at twice its rate
   initial #7 forever #25 async_source_clock = ~async_source_clock;

   // phase lengths and completed conversions
   always @(posedge mclk) begin
      acq_c <= ana_acquire ? acq_c + 1 : 0;
      apx_c <= ana_approx ? apx_c + 1 : 0;
      if (!ana_acquire && acq_c != 0) acq_len <= acq_c;
      if (!ana_approx && apx_c != 0) begin
         apx_len <= apx_c;
         ndone <= ndone + 1;
      end
      if (ana_approx) req_seen <= async_clk_req;
   end

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         miscompares++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk

   task automatic near(input int len, input int n);
      chk(32'(len >= n - 2 && len <= n + 2), 32'h1);
   endtask : near

   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      r = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr

   task automatic rd(input logic [7:0] a);
      apb(1'b0, a, 32'h0);
   endtask : rd

   task automatic conv(input logic [31:0] cmd, input int n,
      input logic [11:0] v);
      int t;
      t = ndone;
      base <= v;
      wr(OFS_CMD, cmd);
      for (int i = 0; i < 9000 && ndone < t + n; i++) @(posedge mclk);
      do rd(OFS_STAT); while (r[SB_BUSY] === 1'b1);
   endtask : conv

   function automatic logic [31:0] ctl(input logic as, input logic od,
      input logic [6:0] pr);
      return 32'h1 << CTRL_EN | 32'(as) << CTRL_ASYNC | 32'(od) << CTRL_ONDEM
         | 32'(pr) << CTRL_ENGINE_PRESCALE | 32'h1 << CTRL_TICK;
   endfunction : ctl

   function automatic logic [31:0] mc(input int a, c, s, o, w);
      return 32'(a) << MC_ACQ | 32'(c) << MC_POS | 32'(s) << MC_RES
         | 32'(o) << MC_OVW | 32'(w) << MC_WM;
   endfunction : mc

   function automatic int acq(input int c);
      return c < 3 ? c + 1 : 1 << (c - 1);
   endfunction : acq

   function automatic logic [31:0] tg(input int c, input logic [11:0] v);
      return 32'(c) << 16 | 32'(v + 12'(c));
   endfunction : tg

   task final_report;
      $display("checks %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : final_report

   initial begin
      repeat (60000) @(posedge mclk);
      miscompares++;
      final_report();
   end

   initial begin
      void'($urandom(32'hcd01));
      repeat (20) @(posedge mclk);
      rst_b <= 1'b1;
      repeat (3) @(posedge mclk);
      foreach (ofs[i]) begin
         rd(ofs[i]);
         chk(r, rv[i]);
      end
      rd(8'h30);
      chk({31'h0, err}, 32'h1);
      $display("reset test done");
      // divide by three keeps the conversion clock near 13 MHz
      wr(OFS_CTRL, ctl(1'b0, 1'b1, 7'h2));
      foreach (codes[c]) begin
         for (int s = 0; s < 3; s++) begin
            p = 5'($urandom);
            wr(OFS_SCTL, mc(codes[c], p, s, 0, 0));
            b = 12'($urandom);
            conv(32'h1 << CMD_SSTART, 1, b);
            rd(OFS_SDATA);
            chk(r, 32'(b + 12'(p)));
            near(acq_len, acq(codes[c]) * 3);
            near(apx_len, ((s == 0 ? 12 : s == 1 ? 8 : 6) + 1) * 3);
         end
      end
      $display("timing test done");
      for (int o = 0; o < 2; o++) begin
         wr(OFS_STAT, 32'h7f00);
         wr(OFS_SCTL, mc(1, p, 2, o, 1));
         for (int i = 0; i < 5; i++) begin
            b = 12'($urandom);
            conv(32'h1 << CMD_SSTART, 1, b);
            q[i] = b + 12'(p);
            if (i < 2) chk(32'(r[SB_SDV]), 32'(i == 1));
         end
         chk(32'(r[SB_EV + EV_SOVF]), 32'h1);
         rd(OFS_SPEEK);
         chk(r, 32'(q[3 + o]));
         for (int i = 0; i < 4; i++) begin
            rd(OFS_SDATA);
            chk(r, 32'(q[i + o]));
            if (i == 2) rd(OFS_STAT);
            if (i == 2) chk(32'(r[SB_SDV]), 32'h0);
         end
         rd(OFS_SDATA);
         rd(OFS_STAT);
         chk(32'(r[SB_EV + EV_SUNF]), 32'h1);
      end
      $display("fifo test done");
      wr(OFS_SCTL, mc(0, 0, 2, 0, 0) | 32'h1 << MC_CMP);
      for (int i = 0; i < 4; i++) begin
         wr(OFS_STAT, 32'h7f00);
         wr(OFS_THR, {4'h0, gt[3 - i], 4'h0, gt[i]});
         conv(32'h1 << CMD_SSTART, 1, vl[i]);
         chk(32'(r[SB_EV + EV_SCMP]), 32'(hit[i]));
         rd(OFS_SDATA);
      end
      $display("compare test done");
      m = 32'h0;
      while ($countones(m) < 3) m |= 32'h1 << ($urandom % 32);
      k = 0;
      for (int i = 0; i < 32; i++) begin
         if (m[i]) ch[k++] = i;
      end
      wr(OFS_MASK, m);
      wr(OFS_NCTL, mc(1, 0, 2, 0, 0));
      b = 12'($urandom);
      conv(32'h1 << CMD_NSTART, 3, b);
      rd(OFS_NPEEK);
      chk(r, tg(ch[2], b));
      rd(OFS_NDATX);
      chk(r, tg(ch[0], b));
      rd(OFS_NDATA);
      chk(r, 32'(b + 12'(ch[1])));
      rd(OFS_NDATX);
      chk(r, tg(ch[2], b));
      // repeated scan, no gap then a gap; fifo keeps the first four
      for (int g = 0; g < 2; g++) begin
         wr(OFS_NCTL, mc(1, 0, 2, 0, 0) | 32'h1 << MC_REP
            | 32'(2 * g) << MC_GAP);
         k = ndone;
         wr(OFS_CMD, 32'h1 << CMD_NSTART);
         for (int i = 0; i < 9000 && ndone < k + 4; i++) @(posedge mclk);
         wr(OFS_CMD, 32'h1 << CMD_NSTOP);
         do rd(OFS_STAT); while (r[SB_BUSY] === 1'b1);
         for (int i = 0; i < 4; i++) begin
            rd(OFS_NDATX);
            m = (i == 2 && g == 0) ? 32'(b + 12'(ch[2])) : tg(ch[i % 3], b);
            chk(r, m);
         end
      end
      $display("scan test done");
      wr(OFS_CTRL, ctl(1'b1, 1'b1, 7'h1));
      wr(OFS_SCTL, mc(0, p, 0, 0, 0));
      chk(32'(async_clk_req), 32'h0);
      b = 12'($urandom);
      conv(32'h1 << CMD_SSTART, 1, b);
      chk(32'(req_seen), 32'h1);
      chk(32'(async_clk_req), 32'h0);
      rd(OFS_SDATA);
      chk(r, 32'(b + 12'(p)));
      wr(OFS_CTRL, ctl(1'b1, 1'b0, 7'h1));
      rd(OFS_STAT);
      chk(32'(async_clk_req), 32'h1);
      wr(OFS_CTRL, ctl(1'b0, 1'b0, 7'h2));
      rd(OFS_STAT);
      chk(32'(async_clk_req), 32'h0);
      $display("clock request test done");
      wr(OFS_STAT, 32'h7f00);
      wr(OFS_SCTL, mc(0, 2, 0, 0, 0) | 32'h1 << MC_DIFFERENTIAL_SELECT | 32'h4 << MC_NEG);
      conv(32'h1 << CMD_SSTART, 1, 12'h0);
      chk(32'(r[SB_EV + EV_PAIR]), 32'h1);
      $display("pair test done");
      final_report();
   end
endmodule : sar_adc_sequencer_control_tb_top
